// ---- src/eam_pkg.sv ----
// Purpose: shared constants and types of the external alarm mapper
// Assumes: axi4-lite register access, 32-bit data
// Notes: offsets are byte addresses
package eam_pkg;
    localparam int EAM_NUM_IN = 2;
    localparam int EAM_NUM_OUT = 4;
    localparam logic [7:0] EAM_OFS_IN_CFG = 8'h00;
    localparam logic [7:0] EAM_OFS_OUT_MAP = 8'h04;
    localparam logic [7:0] EAM_OFS_CTRL = 8'h08;
    localparam logic [7:0] EAM_OFS_CMD = 8'h0c;
    localparam logic [7:0] EAM_OFS_STATUS = 8'h10;
    localparam logic [7:0] EAM_OFS_ACT_IN = 8'h14;
    localparam logic [7:0] EAM_OFS_ACT_OUT = 8'h18;
    // per input field: bit0 polarity, bit1 local display, bit2 major
    localparam int EAM_IN_FLD_W = 4;
    localparam int EAM_IN_POL_BIT = 0;
    localparam int EAM_IN_DISP_BIT = 1;
    localparam int EAM_IN_SEV_BIT = 2;
    localparam int EAM_OUT_FLD_W = 4;
    localparam int EAM_CTRL_RELAY_BIT = 0;
    localparam int EAM_CTRL_PSW_BIT = 1;
    localparam int EAM_CMD_APPLY_BIT = 0;
    localparam int EAM_CMD_REVERT_BIT = 1;
    localparam logic [1:0] EAM_RESP_OKAY = 2'b00;
    localparam logic [1:0] EAM_RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        EAM_SRC_NONE = 4'h0,
        EAM_SRC_LOC_MAJ = 4'h1,
        EAM_SRC_LOC_MIN = 4'h2,
        EAM_SRC_REM_MAJ = 4'h3,
        EAM_SRC_REM_MIN = 4'h4,
        EAM_SRC_REM_IN1 = 4'h5,
        EAM_SRC_REM_IN2 = 4'h6,
        EAM_SRC_TST_MAJ = 4'h7,
        EAM_SRC_TST_MIN = 4'h8
    } eam_src_t;

    typedef struct packed {
        logic [EAM_NUM_IN-1:0] pol_off;
        logic [EAM_NUM_IN-1:0] disp;
        logic [EAM_NUM_IN-1:0] major;
        eam_src_t [EAM_NUM_OUT-1:0] map;
        logic relay_on_alarm;
        logic psw_mode;
    } eam_cfg_t;

    // remote status as received from the peer terminal
    typedef struct packed {
        logic major;
        logic minor;
        logic [EAM_NUM_IN-1:0] inputs;
    } eam_remote_t;
endpackage : eam_pkg

// ---- src/eam_mapper.sv ----
// Purpose: external alarm input conditioning and relay output mapping
// Assumes: single clock, axi4-lite slave, link status already decoded
// Notes: configuration is edited in a pending copy and applied on command
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - two alarm inputs and four relay outputs per terminal
// - per-input polarity: active on current (default) or on no current
// - display off (default): active input raises no local alarm or log
// - display on: active input raises local alarm for logging and summary
// - per-input severity minor (default) or major, used only when displayed
// - conditioned local input states always sent to the remote terminal
// - protection switch mode removes input 2 from user alarm processing
// - output source none (default) keeps the output inactive
// - local major/minor source follows local alarm of that severity
// - remote major/minor source follows received remote alarm status
// - remote input source follows received remote input 1 or 2
// - test source forces output active, no log, no health change
// - test selections cleared on restart
// - one relay polarity for all four outputs
// - edits pending until apply; revert restores active configuration
module eam_mapper
    import eam_pkg::*;
#(
    parameter logic RELAY_ON_ALARM_RST = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [EAM_NUM_IN-1:0] contact_in,
    input wire eam_remote_t remote_in,
    input wire logic local_sys_major,
    input wire logic local_sys_minor,
    output logic [EAM_NUM_IN-1:0] tx_input_state,
    output logic local_ext_major,
    output logic local_ext_minor,
    output logic [EAM_NUM_IN-1:0] ext_log_req,
    output logic psw_ctrl_in,
    output logic [EAM_NUM_OUT-1:0] relay_closed
);
    localparam eam_cfg_t CFG_RST = '{
        pol_off: '0, disp: '0, major: '0,
        map: '{default: EAM_SRC_NONE},
        relay_on_alarm: RELAY_ON_ALARM_RST, psw_mode: 1'b0};

    eam_cfg_t act_q, act_d, pend_q, pend_d;
    logic [EAM_NUM_IN-1:0] cin_s1_q, cin_s2_q;
    eam_remote_t rem_s1_q, rem_s2_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;

    // synchronisers: first stage read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cin_s1_q <= '0;
            cin_s2_q <= '0;
            rem_s1_q <= '0;
            rem_s2_q <= '0;
        end else begin
            cin_s1_q <= contact_in;
            cin_s2_q <= cin_s1_q;
            rem_s1_q <= remote_in;
            rem_s2_q <= rem_s1_q;
        end
    end

    // input conditioning
    wire [EAM_NUM_IN-1:0] in_active = cin_s2_q ^ act_q.pol_off;
    wire [EAM_NUM_IN-1:0] user_mask = act_q.psw_mode ?
        {{(EAM_NUM_IN-1){1'b0}}, 1'b1} : {EAM_NUM_IN{1'b1}};
    wire [EAM_NUM_IN-1:0] shown = in_active & act_q.disp & user_mask;
    wire ext_maj = |(shown & act_q.major);
    wire ext_min = |(shown & ~act_q.major);
    // system alarms are assumed to exclude ext_*, so ext_* are ORed in here
    wire loc_maj = local_sys_major | ext_maj;
    wire loc_min = local_sys_minor | ext_min;

    // output mapping
    logic [EAM_NUM_OUT-1:0] mapped;
    always_comb begin
        for (int i = 0; i < EAM_NUM_OUT; i++) begin
            unique case (act_q.map[i])
                EAM_SRC_NONE: mapped[i] = 1'b0;
                EAM_SRC_LOC_MAJ: mapped[i] = loc_maj;
                EAM_SRC_LOC_MIN: mapped[i] = loc_min;
                EAM_SRC_REM_MAJ: mapped[i] = rem_s2_q.major;
                EAM_SRC_REM_MIN: mapped[i] = rem_s2_q.minor;
                EAM_SRC_REM_IN1: mapped[i] = rem_s2_q.inputs[0];
                EAM_SRC_REM_IN2: mapped[i] = rem_s2_q.inputs[1];
                EAM_SRC_TST_MAJ, EAM_SRC_TST_MIN: mapped[i] = 1'b1;
                default: mapped[i] = 1'b0;
            endcase
        end
    end
    // relay closed on alarm active, or on alarm inactive
    wire [EAM_NUM_OUT-1:0] relay_d = act_q.relay_on_alarm ?
        mapped : ~mapped;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_input_state <= '0;
            local_ext_major <= 1'b0;
            local_ext_minor <= 1'b0;
            ext_log_req <= '0;
            psw_ctrl_in <= 1'b0;
            relay_closed <= '0;
        end else begin
            tx_input_state <= in_active;
            local_ext_major <= ext_maj;
            local_ext_minor <= ext_min;
            ext_log_req <= shown;
            psw_ctrl_in <= in_active[1] & act_q.psw_mode;
            relay_closed <= relay_d;
        end
    end

    // axi4-lite write path
    wire aw_have = aw_hold_q | s_axi_awvalid;
    wire w_have = w_hold_q | s_axi_wvalid;
    wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
    wire [7:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
    wire wr_ok = (wa == EAM_OFS_IN_CFG) | (wa == EAM_OFS_OUT_MAP) |
        (wa == EAM_OFS_CTRL) | (wa == EAM_OFS_CMD);
    wire wr_b0 = wr_fire & s_axi_wstrb[0];
    wire wr_b1 = wr_fire & s_axi_wstrb[1];
    wire do_apply = wr_b0 & (wa == EAM_OFS_CMD) & wd[EAM_CMD_APPLY_BIT];
    wire do_revert = wr_b0 & (wa == EAM_OFS_CMD) & wd[EAM_CMD_REVERT_BIT];

    function automatic eam_src_t to_src(input logic [3:0] v);
        to_src = (v > 4'h8) ? EAM_SRC_NONE : eam_src_t'(v);
    endfunction : to_src

    always_comb begin
        pend_d = pend_q;
        act_d = act_q;
        if (wr_b0 && wa == EAM_OFS_IN_CFG) begin
            for (int i = 0; i < EAM_NUM_IN; i++) begin
                pend_d.pol_off[i] = wd[i*EAM_IN_FLD_W + EAM_IN_POL_BIT];
                pend_d.disp[i] = wd[i*EAM_IN_FLD_W + EAM_IN_DISP_BIT];
                pend_d.major[i] = wd[i*EAM_IN_FLD_W + EAM_IN_SEV_BIT];
            end
        end
        if (wa == EAM_OFS_OUT_MAP) begin
            if (wr_b0) begin
                pend_d.map[0] = to_src(wd[3:0]);
                pend_d.map[1] = to_src(wd[7:4]);
            end
            if (wr_b1) begin
                pend_d.map[2] = to_src(wd[11:8]);
                pend_d.map[3] = to_src(wd[15:12]);
            end
        end
        if (wr_b0 && wa == EAM_OFS_CTRL) begin
            pend_d.relay_on_alarm = wd[EAM_CTRL_RELAY_BIT];
            pend_d.psw_mode = wd[EAM_CTRL_PSW_BIT];
        end
        if (do_apply) begin
            act_d = pend_q;
        end else if (do_revert) begin
            pend_d = act_q;
        end
    end

    // reset loads defaults, so no test source survives a restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_q <= CFG_RST;
            pend_q <= CFG_RST;
        end else begin
            act_q <= act_d;
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= EAM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= ~wr_fire;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= ~wr_fire;
                wdata_q <= s_axi_wdata;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? EAM_RESP_OKAY : EAM_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // ready only while the holding slot is free and no response pending
    always_comb begin
        s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
        s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
    end

    // axi4-lite read path
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            EAM_OFS_IN_CFG, EAM_OFS_ACT_IN: begin
                for (int i = 0; i < EAM_NUM_IN; i++) begin
                    rd_word[i*EAM_IN_FLD_W + EAM_IN_POL_BIT] =
                        (s_axi_araddr == EAM_OFS_IN_CFG) ?
                        pend_q.pol_off[i] : act_q.pol_off[i];
                    rd_word[i*EAM_IN_FLD_W + EAM_IN_DISP_BIT] =
                        (s_axi_araddr == EAM_OFS_IN_CFG) ?
                        pend_q.disp[i] : act_q.disp[i];
                    rd_word[i*EAM_IN_FLD_W + EAM_IN_SEV_BIT] =
                        (s_axi_araddr == EAM_OFS_IN_CFG) ?
                        pend_q.major[i] : act_q.major[i];
                end
            end
            EAM_OFS_OUT_MAP: rd_word[15:0] = pend_q.map;
            EAM_OFS_ACT_OUT: rd_word[15:0] = act_q.map;
            EAM_OFS_CTRL: rd_word[1:0] = {pend_q.psw_mode,
                pend_q.relay_on_alarm};
            EAM_OFS_CMD: rd_word = '0;
            EAM_OFS_STATUS: rd_word[9:0] = {relay_closed, rem_s2_q,
                in_active};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= EAM_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? EAM_RESP_OKAY : EAM_RESP_SLVERR;
            end
        end
    end

    // assertions
    property p_none_idle;
        @(posedge aclk) disable iff (!aresetn)
        aresetn && (act_q.map[0] == EAM_SRC_NONE) |=>
            (relay_closed[0] == ~$past(act_q.relay_on_alarm));
    endproperty
    a_none_idle: assert property (p_none_idle)
        else $error("unmapped output not inactive");
    property p_test_force;
        @(posedge aclk) disable iff (!aresetn)
        (act_q.map[1] == EAM_SRC_TST_MAJ) && $stable(act_q) |=>
            (relay_closed[1] == $past(act_q.relay_on_alarm));
    endproperty
    a_test_force: assert property (p_test_force)
        else $error("test source not forcing");
    property p_hidden;
        @(posedge aclk) disable iff (!aresetn)
        (act_q.disp == '0) |=> !local_ext_major && !local_ext_minor
            && ext_log_req == '0;
    endproperty
    a_hidden: assert property (p_hidden)
        else $error("hidden input raised alarm");
    property p_tx;
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> tx_input_state == $past(cin_s2_q ^ act_q.pol_off);
    endproperty
    a_tx: assert property (p_tx)
        else $error("input state not sent");
    property p_sync;
        @(posedge aclk) disable iff (!aresetn)
        aresetn |=> ##1 cin_s2_q == $past(contact_in, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("synchroniser latency wrong");
    property p_psw;
        @(posedge aclk) disable iff (!aresetn)
        act_q.psw_mode |=> !ext_log_req[1];
    endproperty
    a_psw: assert property (p_psw)
        else $error("input 2 used while switch mode on");
    property p_apply;
        @(posedge aclk) disable iff (!aresetn)
        do_apply |=> act_q == $past(pend_q);
    endproperty
    a_apply: assert property (p_apply)
        else $error("apply did not load pending");
    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        !do_apply |=> act_q == $past(act_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("active config changed without apply");
    property p_remin;
        @(posedge aclk) disable iff (!aresetn)
        (act_q.map[2] == EAM_SRC_REM_IN1) && $stable(act_q) |=>
            relay_closed[2] == ($past(rem_s2_q.inputs[0])
            ~^ $past(act_q.relay_on_alarm));
    endproperty
    a_remin: assert property (p_remin)
        else $error("remote input not followed");
    c_apply: cover property (@(posedge aclk) do_apply);
    c_revert: cover property (@(posedge aclk) do_revert);
    c_major: cover property (@(posedge aclk) local_ext_major);
    c_wr_err: cover property (@(posedge aclk)
        s_axi_bvalid && s_axi_bresp == EAM_RESP_SLVERR);
endmodule : eam_mapper

// ---- test/eam_peer.sv ----
// Purpose: behavioural peer terminal on the far side of the alarm link
// Assumes: peer alarm states set by the bench, one register of latency
// Notes: hold freezes the link to mimic a slow peer
`timescale 1ns/1ps
module eam_peer
    import eam_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hold,
    input wire logic [EAM_NUM_IN-1:0] rx_state,
    input wire logic [EAM_NUM_IN-1:0] own_mapped,
    input wire eam_remote_t own_state,
    output eam_remote_t remote_out,
    output logic [EAM_NUM_IN-1:0] peer_log
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remote_out <= '0;
            peer_log <= '0;
        end else if (!hold) begin
            remote_out <= own_state;
            // logged only when mapped to one of the peer's outputs
            peer_log <= rx_state & own_mapped;
        end
    end
endmodule : eam_peer

// ---- test/tb.sv ----
// Purpose: self-checking bench for the external alarm mapper
// Assumes: axi4-lite master tasks, peer model on the link side
// Notes: level outputs are judged after a settle of 8 edges
`timescale 1ns/1ps
module tb;
    import eam_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, lmaj, lmin, hold, emaj, emin;
    logic psw;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, relay;
    logic [1:0] bresp, rresp, contact, tx, logr, plog, mapped;
    eam_remote_t remote, own;
    int fail_count, comparisons;

    eam_mapper u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .contact_in(contact), .remote_in(remote),
        .local_sys_major(lmaj), .local_sys_minor(lmin),
        .tx_input_state(tx), .local_ext_major(emaj),
        .local_ext_minor(emin), .ext_log_req(logr),
        .psw_ctrl_in(psw), .relay_closed(relay)
    );
    eam_peer u_peer (
        .aclk(aclk), .aresetn(aresetn), .hold(hold), .rx_state(tx),
        .own_mapped(mapped), .own_state(own), .remote_out(remote),
        .peer_log(plog)
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        if (bvalid !== 1'b1) begin
            chk(32'h0000_0000, 32'h0000_0001, "write timeout");
            give_verdict();
        end
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        logic ar_ok;
        n = 0;
        ar_ok = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready && !ar_ok) begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1 && n < 40);
        rready <= 1'b0;
        if (rvalid !== 1'b1) begin
            chk(32'h0000_0000, 32'h0000_0001, "read timeout");
            give_verdict();
        end
        chk({30'h0, rresp}, {30'h0, er}, "read response");
        if (er == EAM_RESP_OKAY) begin
            chk(rdata, ed, "read data");
        end
    endtask : rd

    task automatic settle();
        repeat (8) @(posedge aclk);
    endtask : settle

    task automatic apply();
        wr(EAM_OFS_CMD, 32'h0000_0001, EAM_RESP_OKAY);
        settle();
    endtask : apply

    // expected alarm from the bench's own stimulus, display kept off
    function automatic logic exp_al(input logic [3:0] c);
        case (c)
            4'h1: return lmaj;
            4'h2: return lmin;
            4'h3: return own.major;
            4'h4: return own.minor;
            4'h5: return own.inputs[0];
            4'h6: return own.inputs[1];
            4'h7, 4'h8: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : exp_al

    task automatic t_defaults();
        rd(EAM_OFS_IN_CFG, 32'h0000_0000, EAM_RESP_OKAY);
        rd(EAM_OFS_OUT_MAP, 32'h0000_0000, EAM_RESP_OKAY);
        rd(EAM_OFS_CTRL, 32'h0000_0000, EAM_RESP_OKAY);
        chk({28'h0, relay}, 32'h0000_000f, "idle relays");
    endtask : t_defaults

    task automatic t_map();
        logic [3:0] c;
        wr(EAM_OFS_CTRL, 32'h0000_0001, EAM_RESP_OKAY);
        for (int p = 0; p < 2; p++) begin
            hold <= 1'b1;
            lmaj <= !p[0];
            lmin <= p[0];
            own <= p[0] ? 4'b0110 : 4'b1001;
            repeat (3) @(posedge aclk);
            hold <= 1'b0;
            for (int k = 0; k < 9; k++) begin
                c = k[3:0];
                wr(EAM_OFS_OUT_MAP, {16'h0, c, c, c, c}, EAM_RESP_OKAY);
                apply();
                chk({28'h0, relay}, {28'h0, {4{exp_al(c)}}},
                    "map");
                chk({27'h0, emaj, emin, logr, psw}, 32'h0, "no log");
            end
        end
        wr(EAM_OFS_OUT_MAP, 32'h0000_8531, EAM_RESP_OKAY);
        apply();
        chk({28'h0, relay}, {28'h0, 1'b1, exp_al(4'h5), exp_al(4'h3),
            exp_al(4'h1)}, "mixed map");
    endtask : t_map

    task automatic t_inputs();
        contact <= 2'b11;
        wr(EAM_OFS_IN_CFG, 32'h0000_0036, EAM_RESP_OKAY);
        settle();
        chk({30'h0, tx}, 32'h0000_0003, "tx default");
        chk({27'h0, emaj, emin, logr, psw}, 32'h0, "hidden");
        rd(EAM_OFS_ACT_IN, 32'h0000_0000, EAM_RESP_OKAY);
        wr(EAM_OFS_CMD, 32'h0000_0002, EAM_RESP_OKAY);
        rd(EAM_OFS_IN_CFG, 32'h0000_0000, EAM_RESP_OKAY);
        wr(EAM_OFS_IN_CFG, 32'h0000_0036, EAM_RESP_OKAY);
        apply();
        rd(EAM_OFS_ACT_IN, 32'h0000_0036, EAM_RESP_OKAY);
        chk({30'h0, tx}, 32'h0000_0001, "tx polarity");
        chk({27'h0, emaj, emin, logr, psw}, 32'h0000_0012, "major");
        contact <= 2'b00;
        settle();
        chk({30'h0, tx}, 32'h0000_0002, "tx swap");
        chk({27'h0, emaj, emin, logr, psw}, 32'h0000_000c, "minor");
    endtask : t_inputs

    task automatic t_psw();
        wr(EAM_OFS_CTRL, 32'h0000_0002, EAM_RESP_OKAY);
        apply();
        chk({29'h0, tx, psw}, 32'h0000_0005, "psw ctrl");
        chk({28'h0, emaj, emin, logr}, 32'h0, "psw no alarm");
        chk({28'h0, relay}, {28'h0, 1'b0, !exp_al(4'h5), !exp_al(4'h3),
            !exp_al(4'h1)}, "relay polarity");
        chk({30'h0, plog}, 32'h0000_0002, "peer log");
    endtask : t_psw

    task automatic t_bus();
        rd(8'h1c, 32'h0, EAM_RESP_SLVERR);
        wr(EAM_OFS_STATUS, 32'h0000_0fff, EAM_RESP_SLVERR);
        wr(8'h40, 32'h0000_0001, EAM_RESP_SLVERR);
        rd(EAM_OFS_ACT_OUT, 32'h0000_8531, EAM_RESP_OKAY);
        rd(EAM_OFS_STATUS, 32'h0000_01da, EAM_RESP_OKAY);
        wr(EAM_OFS_OUT_MAP, 32'h0000_f531, EAM_RESP_OKAY);
        rd(EAM_OFS_OUT_MAP, 32'h0000_0531, EAM_RESP_OKAY);
    endtask : t_bus

    task automatic t_restart();
        wr(EAM_OFS_OUT_MAP, 32'h0000_8787, EAM_RESP_OKAY);
        apply();
        chk({28'h0, relay}, 32'h0000_0000, "test forced");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        rd(EAM_OFS_ACT_OUT, 32'h0000_0000, EAM_RESP_OKAY);
        chk({28'h0, relay}, 32'h0000_000f, "test cleared");
    endtask : t_restart

    initial begin
        fail_count = 0;
        comparisons = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        contact = 2'b00;
        lmaj = 1'b0;
        lmin = 1'b0;
        hold = 1'b0;
        own = 4'h0;
        mapped = 2'b10;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        t_defaults();
        t_map();
        t_inputs();
        t_psw();
        t_bus();
        t_restart();
        give_verdict();
    end
endmodule : tb
